//--- mmac_fabric.sv
// Purpose: fabric-side driver of the slice operands
// Assumes: requests come from the bench one cycle ahead
// Notes:   idle operands flip every cycle so stale data cannot match
module mmac_fabric
    import mmac_pkg::*;
(
    // clock and reset
    input  wire logic     ref_clk,
    input  wire logic     rst,
    // bench request and slice operands
    input  wire mmac_in_s req,
    output mmac_in_s      din
);
    timeunit 1ns;
    timeprecision 100ps;
    initial din = '0;
    always @(posedge ref_clk) begin : p_drive
        mmac_in_s idle;
        idle       = ~din;
        idle.valid = 1'b0;
        if (req.valid && !rst) begin
            din <= req;
        end else begin
            din <= idle;
        end
    end
endmodule // mmac_fabric

//--- mmac_lane.sv
// Purpose: one integer multiply, shift and add/sub/accumulate lane
// Assumes: ref_clk domain, operands already aligned to bit 0
// Notes:   result register wraps modulo its own width
module mmac_lane
    import mmac_pkg::*;
#(
    parameter int AW = 4,
    parameter int BW = 4,
    parameter int RW = 12
) (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // configuration
    input  wire logic            sgn,
    input  wire mmac_op_e        op,
    // operands
    input  wire logic            en,
    input  wire logic            acc_load,
    input  wire logic [AW-1:0]   a,
    input  wire logic [BW-1:0]   b,
    input  wire logic [RW-1:0]   c,
    input  wire logic [SH_W-1:0] shamt,
    // result
    output logic      [RW-1:0]   acc
);
    localparam int PW = (AW + BW + 2 > RW) ? AW + BW + 2 : RW;

    logic signed [AW:0]   ax;
    logic signed [BW:0]   bx;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] shifted;
    logic [SH_W-1:0]      sh;
    logic [RW-1:0]        pr;
    logic [RW-1:0]        next_acc;

    // unsigned operands get a zero top bit so one signed multiplier serves
    assign ax = sgn ? {a[AW-1], a} : {1'b0, a}; // RL7
    assign bx = sgn ? {b[BW-1], b} : {1'b0, b}; // RL7
    assign prod = ax * bx;
    assign sh = (shamt > SHIFT_MAX) ? SHIFT_MAX : shamt;
    assign shifted = prod >>> sh; // RL5
    assign pr = shifted[RW-1:0];

    always_comb begin
        case (op)
            MMAC_MULT: next_acc = pr; // RL10
            MMAC_ADD:  next_acc = pr + c; // RL6
            MMAC_SUB:  next_acc = pr - c; // RL6
            MMAC_ACC:  next_acc = acc_load ? pr : acc + pr; // RL6 RL13
            default:   next_acc = pr;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            acc <= '0;
        end else if (en) begin
            acc <= next_acc;
        end
    end
endmodule // mmac_lane

//--- mmac_pkg.sv
// Purpose: shared types and constants for the multimode multiply-accumulate
// Assumes: one clock, synchronous active-high reset
// Notes:   operand fields are packed from bit 0 upward in every mode
package mmac_pkg;

    // operating modes and arithmetic selections
    typedef enum logic [1:0] {
        MMAC_NORMAL,
        MMAC_DUAL,
        MMAC_QUAD,
        MMAC_FLOAT
    } mmac_mode_e;

    typedef enum logic [1:0] {
        MMAC_MULT,
        MMAC_ADD,
        MMAC_SUB,
        MMAC_ACC
    } mmac_op_e;

    // operand and result widths
    localparam int A_W      = 19;
    localparam int B_W      = 18;
    localparam int R_W      = 48;
    localparam int DA0_W    = 11;
    localparam int DB0_W    = 10;
    localparam int D1_W     = 8;
    localparam int DR_W     = 24;
    localparam int QA0_W    = 7;
    localparam int QB0_W    = 6;
    localparam int Q1_W     = 4;
    localparam int QR_W     = 12;
    localparam int LANES    = 4;
    localparam int SH_W     = 3;
    localparam logic [SH_W-1:0] SHIFT_MAX = 3'h4;

    // brain-float layout
    localparam int BF_W     = 16;
    localparam int BF_EXP_W = 8;
    localparam int BF_MAN_W = 7;
    localparam int BF_BIAS  = 127;
    localparam logic [BF_EXP_W-1:0] BF_EXP_MAX = 8'hff;

    typedef struct packed {
        logic                        valid;
        logic                        acc_load;
        logic [A_W-1:0]              a;
        logic [B_W-1:0]              b;
        logic [R_W-1:0]              c;
        logic [LANES-1:0][SH_W-1:0]  shamt;
    } mmac_in_s;

    typedef struct packed {
        logic           valid;
        logic [R_W-1:0] result;
    } mmac_out_s;

endpackage

//--- mmac_ref_pkg.sv
// Purpose: reference lane product shared by checker and bench
// Assumes: operands at bit 0, widths below 32
// Notes:   shift clamps at 4, sign by flag
package mmac_ref_pkg;
    function automatic longint lp(longint a, longint b, int aw, int bw,
                                  int sh, bit s);
        longint x;
        longint y;
        x = a & ((64'sh1 << aw) - 1);
        y = b & ((64'sh1 << bw) - 1);
        if (s && x[aw-1]) x -= 64'sh1 << aw;
        if (s && y[bw-1]) y -= 64'sh1 << bw;
        return (x * y) >>> ((sh > 4) ? 4 : sh);
    endfunction
endpackage

//--- mmac_top.sv
// Purpose: multimode multiply-accumulate slice fed by fabric logic
// Assumes: static mode, sign and op parameters; one ref_clk domain
// Notes:   two cycles from in.valid to out.valid in every mode
//
// Operation
// RL1 - Normal mode multiplies 19 by 18 bits into one 48-bit adder/subtractor.
// RL2 - Dual mode runs an 11 by 10 and an 8 by 8 lane, each with a 24-bit adder.
// RL3 - Quad mode runs a 7 by 6 and three 4 by 4 lanes, each 12-bit wide.
// RL4 - Float mode does one fused brain-float multiply-add, rounding once.
// RL5 - A right shift of up to 4 bits applies to every integer lane in use.
// RL6 - Multiply, add, subtract and accumulate are offered, with running sum.
// RL7 - Integer operands are signed or unsigned by a static sign setting.
// RL8 - All lanes of one block share the one sign setting.
// RL9 - The fabric drives the two multiplier operands on inputs a and b.
// RL10 - The product can go straight out or through the add/sub stage.
// RL11 - Exactly four modes exist, chosen per block.
// RL12 - Mode, sign and op are static parameters fixed for operation.
// RL13 - Each integer accumulator wraps modulo its own lane width.
module mmac_top
    import mmac_pkg::*;
#(
    parameter mmac_mode_e MODE        = MMAC_NORMAL, // RL11 RL12
    parameter logic       SIGNED_MODE = 1'b1,        // RL8 RL12
    parameter mmac_op_e   OP          = MMAC_MULT    // RL12
) (
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      rst,
    // operands from fabric
    input  wire mmac_in_s  din,
    // results to fabric
    output mmac_out_s      dout
);
    logic [R_W-1:0] lane_res;
    logic           v1;

    // one sign setting for the whole block, no per-lane override
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            v1 <= 1'b0;
        end else begin
            v1 <= din.valid;
        end
    end

    generate
        if (MODE == MMAC_NORMAL) begin : g_normal
            mmac_lane #(.AW(A_W), .BW(B_W), .RW(R_W)) u_lane ( // RL1
                .ref_clk  (ref_clk),
                .rst      (rst),
                .sgn      (SIGNED_MODE),
                .op       (OP),
                .en       (din.valid),
                .acc_load (din.acc_load),
                .a        (din.a), // RL9
                .b        (din.b), // RL9
                .c        (din.c),
                .shamt    (din.shamt[0]),
                .acc      (lane_res)
            );
        end else if (MODE == MMAC_DUAL) begin : g_dual
            mmac_lane #(.AW(DA0_W), .BW(DB0_W), .RW(DR_W)) u_lane0 ( // RL2
                .ref_clk  (ref_clk),
                .rst      (rst),
                .sgn      (SIGNED_MODE),
                .op       (OP),
                .en       (din.valid),
                .acc_load (din.acc_load),
                .a        (din.a[DA0_W-1:0]),
                .b        (din.b[DB0_W-1:0]),
                .c        (din.c[DR_W-1:0]),
                .shamt    (din.shamt[0]),
                .acc      (lane_res[DR_W-1:0])
            );
            mmac_lane #(.AW(D1_W), .BW(D1_W), .RW(DR_W)) u_lane1 ( // RL2
                .ref_clk  (ref_clk),
                .rst      (rst),
                .sgn      (SIGNED_MODE),
                .op       (OP),
                .en       (din.valid),
                .acc_load (din.acc_load),
                .a        (din.a[DA0_W +: D1_W]),
                .b        (din.b[DB0_W +: D1_W]),
                .c        (din.c[DR_W +: DR_W]),
                .shamt    (din.shamt[1]),
                .acc      (lane_res[DR_W +: DR_W])
            );
        end else if (MODE == MMAC_QUAD) begin : g_quad
            mmac_lane #(.AW(QA0_W), .BW(QB0_W), .RW(QR_W)) u_lane0 ( // RL3
                .ref_clk  (ref_clk),
                .rst      (rst),
                .sgn      (SIGNED_MODE),
                .op       (OP),
                .en       (din.valid),
                .acc_load (din.acc_load),
                .a        (din.a[QA0_W-1:0]),
                .b        (din.b[QB0_W-1:0]),
                .c        (din.c[QR_W-1:0]),
                .shamt    (din.shamt[0]),
                .acc      (lane_res[QR_W-1:0])
            );
            for (genvar i = 1; i < LANES; i++) begin : g_small
                mmac_lane #(.AW(Q1_W), .BW(Q1_W), .RW(QR_W)) u_lane ( // RL3
                    .ref_clk  (ref_clk),
                    .rst      (rst),
                    .sgn      (SIGNED_MODE),
                    .op       (OP),
                    .en       (din.valid),
                    .acc_load (din.acc_load),
                    .a        (din.a[QA0_W + (i-1)*Q1_W +: Q1_W]),
                    .b        (din.b[QB0_W + (i-1)*Q1_W +: Q1_W]),
                    .c        (din.c[i*QR_W +: QR_W]),
                    .shamt    (din.shamt[i]), // RL5
                    .acc      (lane_res[i*QR_W +: QR_W])
                );
            end
        end else begin : g_float
            logic [BF_W-1:0] facc;
            logic [BF_W-1:0] next_facc;
            logic            zs;
            logic [BF_EXP_W-1:0] ze;
            logic [BF_MAN_W-1:0] zf;

            // addend picked by the static op; subtract flips its sign
            always_comb begin
                case (OP)
                    MMAC_ADD: {zs, ze, zf} = din.c[BF_W-1:0];
                    MMAC_SUB: {zs, ze, zf} = din.c[BF_W-1:0] ^ 16'h8000;
                    MMAC_ACC: {zs, ze, zf} = din.acc_load ? 16'h0000 : facc;
                    default:  {zs, ze, zf} = 16'h0000; // RL10
                endcase
            end

            // exact product and sum, one rounding at the end
            // subnormals flush to zero; no nan or infinity inputs handled
            always_comb begin
                int   ea;
                int   eb;
                int   kp;
                int   kz;
                int   kb;
                int   d;
                int   lead;
                int   ex;
                logic sp;
                logic [15:0] mp;
                logic [15:0] mz;
                logic [33:0] mb;
                logic [33:0] ms;
                logic        sb;
                logic        ss;
                logic signed [34:0] sum;
                logic [32:0] mag;
                logic [32:0] norm;
                logic [8:0]  mant;
                kb = 0;
                d  = 0;
                mb = '0;
                ms = '0;
                sb = 1'b0;
                ss = 1'b0;
                ea = int'(din.a[BF_W-2 -: BF_EXP_W]);
                eb = int'(din.b[BF_W-2 -: BF_EXP_W]);
                kp = ea + eb - BF_BIAS;
                kz = int'(ze);
                sp = din.a[BF_W-1] ^ din.b[BF_W-1];
                mp = (ea == 0 || eb == 0) ? 16'h0000 :
                     {8'h00, 1'b1, din.a[BF_MAN_W-1:0]} *
                     {8'h00, 1'b1, din.b[BF_MAN_W-1:0]}; // RL4
                mz = (kz == 0) ? 16'h0000 : {1'b0, 1'b1, zf, 7'h00};
                if (mp == 16'h0000) begin
                    kp = 0;
                end
                if (kp >= kz) begin
                    kb = kp;
                    d  = kp - kz;
                    mb = {2'b00, mp, 16'h0000};
                    ms = {2'b00, mz, 16'h0000};
                    sb = sp;
                    ss = zs;
                end else begin
                    kb = kz;
                    d  = kz - kp;
                    mb = {2'b00, mz, 16'h0000};
                    ms = {2'b00, mp, 16'h0000};
                    sb = zs;
                    ss = sp;
                end
                ms = (d > 31) ? 34'h0 : ms >> d;
                sum = (sb ? -$signed({1'b0, mb}) : $signed({1'b0, mb})) +
                      (ss ? -$signed({1'b0, ms}) : $signed({1'b0, ms}));
                mag = sum[34] ? 33'(-sum) : sum[32:0];
                lead = 0;
                for (int i = 0; i < 33; i++) begin
                    if (mag[i]) begin
                        lead = i;
                    end
                end
                norm = mag << (32 - lead);
                mant = {1'b0, norm[32:25]} + {8'h00, norm[24]};
                ex = lead + kb - 30;
                if (mant[8]) begin
                    mant = mant >> 1;
                    ex = ex + 1;
                end
                if (mag == 33'h0 || ex <= 0) begin
                    next_facc = 16'h0000;
                end else if (ex >= int'(BF_EXP_MAX)) begin
                    next_facc = {sum[34], BF_EXP_MAX, 7'h00};
                end else begin
                    next_facc = {sum[34], ex[BF_EXP_W-1:0],
                                 mant[BF_MAN_W-1:0]}; // RL4 RL6
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    facc <= '0;
                end else if (din.valid) begin
                    facc <= next_facc;
                end
            end

            assign lane_res = {32'h0000_0000, facc};
        end
    endgenerate

    // result register; only the lanes of the chosen mode are built
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dout <= '0;
        end else begin
            dout.valid  <= v1;
            dout.result <= lane_res;
        end
    end
endmodule // mmac_top

//--- mmac_top_sva.sv
// Purpose: port-level checks of the multiply-accumulate slice
// Assumes: static parameters handed on by the bind
// Notes:   arithmetic checked for normal, quad lanes 0 and 1; float only for zero upper bits and no negative zero
module mmac_top_sva
    import mmac_pkg::*, mmac_ref_pkg::*;
#(
    parameter mmac_mode_e MODE        = MMAC_NORMAL,
    parameter logic       SIGNED_MODE = 1'b1,
    parameter mmac_op_e   OP          = MMAC_MULT
) (
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      rst,
    // slice ports
    input  wire mmac_in_s  din,
    input  wire mmac_out_s dout
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    function automatic longint addend(longint c);
        return (OP == MMAC_ADD) ? c : (OP == MMAC_SUB) ? -c : 64'sh0;
    endfunction
    a_out_latency:
    assert property (din.valid |-> ##2 dout.valid)
        else $error("result strobe late or missing");
    a_no_spurious:
    assert property (dout.valid |-> $past(din.valid, 2))
        else $error("result strobe without operands");
    a_result_hold:
    assert property (!dout.valid |-> $stable(dout.result))
        else $error("result moved without strobe");
    a_reset_clear:
    assert property (disable iff (1'b0)
        rst |=> !dout.valid && dout.result == '0)
        else $error("outputs not cleared by reset");
    a_normal_arith:
    assert property (dout.valid && MODE == MMAC_NORMAL && OP != MMAC_ACC
        |-> dout.result == R_W'(lp($past(din.a, 2), $past(din.b, 2), A_W,
        B_W, $past(din.shamt[0], 2), SIGNED_MODE) + addend($past(din.c, 2))))
        else $error("normal lane result wrong");
    a_quad_load:
    assert property (dout.valid && $past(din.acc_load, 2)
        && MODE == MMAC_QUAD && OP == MMAC_ACC
        |-> dout.result[11:0] == 12'(lp($past(din.a[6:0], 2),
        $past(din.b[5:0], 2), 7, 6, $past(din.shamt[0], 2), SIGNED_MODE)))
        else $error("quad lane 0 load wrong");
    a_acc_running:
    assert property (dout.valid && !$past(din.acc_load, 2)
        && MODE == MMAC_QUAD && OP == MMAC_ACC
        |-> dout.result[23:12] == 12'($past(dout.result[23:12])
        + lp($past(din.a[10:7], 2), $past(din.b[9:6], 2), 4, 4,
        $past(din.shamt[1], 2), SIGNED_MODE)))
        else $error("quad lane 1 running sum wrong");
    a_float_upper:
    assert property (dout.valid && MODE == MMAC_FLOAT
        |-> dout.result[47:16] == '0
        && (dout.result[14:0] != '0 || !dout.result[15]))
        else $error("float upper bits set or negative zero");
endmodule // mmac_top_sva
bind mmac_top mmac_top_sva #(
    .MODE        (MODE),
    .SIGNED_MODE (SIGNED_MODE),
    .OP          (OP)
) u_sva (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (din),
    .dout    (dout)
);

//--- mmac_top_test.sv
// Purpose: self-checking bench for quad, dual, normal and float slices
// Assumes: one shared operand stream feeds every slice
// Notes:   dual slice is multiply-only, so the direct product is seen
module mmac_top_test
    import mmac_pkg::*, mmac_ref_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk     = 1'b0;
    logic        rst         = 1'b1;
    mmac_in_s    req         = '0;
    mmac_in_s    din;
    mmac_out_s   dout_q;
    mmac_out_s   dout_n;
    mmac_out_s   dout_f;
    mmac_out_s   dout_d;
    logic [47:0] accq        = '0;
    logic [47:0] en          = '0;
    logic [47:0] ed          = '0;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          ao[4]       = '{0, 7, 11, 15};
    int          aw[4]       = '{7, 4, 4, 4};
    int          bo[4]       = '{0, 6, 10, 14};
    int          bw[4]       = '{6, 4, 4, 4};
    always #4 ref_clk = ~ref_clk;
    mmac_fabric u_fab (.ref_clk(ref_clk), .rst(rst), .req(req), .din(din));
    mmac_top #(.MODE(MMAC_QUAD), .SIGNED_MODE(1'b1), .OP(MMAC_ACC)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .din(din), .dout(dout_q));
    mmac_top #(.MODE(MMAC_NORMAL), .SIGNED_MODE(1'b0), .OP(MMAC_SUB))
        u_dut_n (.ref_clk(ref_clk), .rst(rst), .din(din), .dout(dout_n));
    mmac_top #(.MODE(MMAC_FLOAT), .SIGNED_MODE(1'b1), .OP(MMAC_ADD))
        u_dut_f (.ref_clk(ref_clk), .rst(rst), .din(din), .dout(dout_f));
    mmac_top #(.MODE(MMAC_DUAL), .SIGNED_MODE(1'b1), .OP(MMAC_MULT))
        u_dut_d (.ref_clk(ref_clk), .rst(rst), .din(din), .dout(dout_d));
    task automatic check(input string nm, input logic [48:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic put(input logic [18:0] a, input logic [17:0] b,
                       input logic [47:0] c, input logic [11:0] sh,
                       input logic ld);
        longint      p;
        logic [11:0] q;
        en = 48'(lp(a, b, A_W, B_W, int'(sh[2:0]), 1'b0) - longint'(c));
        ed[DR_W +: DR_W] = DR_W'(lp(a >> DA0_W, b >> DB0_W, D1_W, D1_W,
                                    int'(sh[5:3]), 1'b1));
        ed[DR_W-1:0] = DR_W'(lp(a, b, DA0_W, DB0_W, int'(sh[2:0]), 1'b1));
        for (int i = 0; i < LANES; i++) begin
            p = lp(a >> ao[i], b >> bo[i], aw[i], bw[i], sh[3*i+:3], 1'b1);
            q = ld ? 12'h000 : accq[12*i+:12];
            accq[12*i+:12] = 12'(q + p);
        end
        @(posedge ref_clk);
        req <= '{1'b1, ld, a, b, c, sh};
    endtask
    task automatic zchk(input string nm);
        check({nm, " q"}, {dout_q.valid, dout_q.result}, 49'h0);
        check({nm, " n"}, {dout_n.valid, dout_n.result}, 49'h0);
        check({nm, " f"}, {dout_f.valid, dout_f.result}, 49'h0);
        check({nm, " d"}, {dout_d.valid, dout_d.result}, 49'h0);
        $display("test %s done", nm);
    endtask
    task automatic done(input string nm, input logic [15:0] fe, input bit fc);
        int n;
        int m;
        @(posedge ref_clk);
        req.valid <= 1'b0;
        #1;
        for (n = 0; n < 8 && dout_q.valid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        for (m = 0; m < 8 && dout_q.valid === 1'b1; m++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 8 || m == 8) begin
            miscompares++;
            report_and_stop();
        end
        check({nm, " q"}, {dout_q.valid, dout_q.result}, {1'b0, accq});
        check({nm, " n"}, {dout_n.valid, dout_n.result}, {1'b0, en});
        check({nm, " d"}, {dout_d.valid, dout_d.result}, {1'b0, ed});
        if (fc)
            check({nm, " f"}, {dout_f.valid, dout_f.result}, {33'h0, fe});
        $display("test %s done", nm);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        zchk("reset");
        put(19'h7_ffff, 18'h3_ffff, 48'h0000_0000_0000, 12'h000, 1'b1);
        done("wide", 16'h0000, 1'b0);
        put(19'h5_a5a5, 18'h2_c3c3, 48'h0000_0001_2345, 12'hfff, 1'b0);
        done("clamp", 16'h0000, 1'b0);
        put(19'h0_3fc0, 18'h0_4000, 48'h0000_0000_3f80, 12'h000, 1'b0);
        done("fp add", 16'h4080, 1'b1);
        put(19'h0_3f80, 18'h0_3f80, 48'h0000_0000_bf80, 12'h000, 1'b0);
        done("fp zero", 16'h0000, 1'b1);
        put(19'h0_c000, 18'h0_4040, 48'h0000_0000_3f80, 12'h000, 1'b0);
        done("fp neg", 16'hc0a0, 1'b1);
        put(19'h1_2345, 18'h2_abcd, 48'h0000_0000_0100, 12'h249, 1'b1);
        put(19'h7_0f0f, 18'h1_f0f0, 48'h0000_0000_0000, 12'h4c1, 1'b0);
        put(19'h4_4444, 18'h3_3333, 48'h1234_5678_9abc, 12'h000, 1'b0);
        put(19'h6_beef, 18'h2_cafe, 48'h0000_0000_ffff, 12'h7ff, 1'b0);
        done("b2b", 16'h0000, 1'b0);
        put(19'h0_0000, 18'h0_0000, 48'h0000_0000_0001, 12'h000, 1'b0);
        done("wrap", 16'h0000, 1'b0);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        accq = '0;
        @(posedge ref_clk);
        #1;
        zchk("mid reset");
        put(19'h3_1234, 18'h1_5678, 48'h0000_0000_0042, 12'h123, 1'b0);
        done("after reset", 16'h0000, 1'b0);
        report_and_stop();
    end
endmodule // mmac_top_test
